// File: design/cmdirq_regs.sv
`timescale 1ns/1ps
`include "cmdirq_consts.svh"
module cmdirq_regs
    import cmdirq_pkg::*;
#(
    parameter int WAKE_CYCLES = `CMDIRQ_WAKE_CYC
) (
    input wire logic ref_clk_i,
    input wire logic resetn_i,
    input wire logic [5:0] reg_addr_i,
    input wire logic reg_wr_i,
    input wire logic reg_rd_i,
    input wire logic [7:0] reg_wdata_i,
    output logic [7:0] reg_rdata_o,
    input wire logic [6:0] comm_event_i,
    input wire logic checksum_done_i,
    input wire logic cmd_done_i,
    input wire logic modulation_input_pin_i,
    output logic receiver_analog_disable_o,
    output logic sleep_o,
    output logic [3:0] cmd_active_o,
    output logic cmd_start_o,
    output logic irq_out_o,
    output logic irq_oe_n_o
);
    // ==========================================================================
    // Elaboration checks
    // The wake counter is sixteen bits wide, so longer wake-up times cannot be counted.
    if (WAKE_CYCLES < 1 || WAKE_CYCLES > 65535) begin : g_bad_wake
        $error("WAKE_CYCLES out of range");
    end

    // ==========================================================================
    // Reset values split into fields
    localparam logic [7:0] CMD_RST = `CMDIRQ_RST_CMD;
    localparam logic RECEIVER_ANALOG_DISABLE_RST = CMD_RST[`CMDIRQ_BIT_RECEIVER_ANALOG_DISABLE];
    localparam logic [3:0] CODE_RST = CMD_RST[3:0];
    localparam logic [6:0] COMIRQ_RST = `CMDIRQ_RST_COMIRQ;

    // ==========================================================================
    // Helpers
    function automatic logic cmd_known(input logic [3:0] c);
        case (c)
            CMDIRQ_IDLE,
            CMDIRQ_MEM,
            CMDIRQ_RANDID,
            CMDIRQ_CALCCRC,
            CMDIRQ_TRANSMIT,
            CMDIRQ_NOCHANGE,
            CMDIRQ_RECEIVE,
            CMDIRQ_TRANSCEIVE,
            CMDIRQ_AUTH,
            CMDIRQ_SOFTWARE_RESTART_CMD: cmd_known = 1'b1;
            default: cmd_known = 1'b0;
        endcase
    endfunction

    // One request flag: the set-or-clear bit picks the effect of a marked write,
    // and a hardware event in the same cycle always wins over a software clear.
    function automatic logic flag_next(input logic cur, input logic wr, input logic [7:0] wd, input logic mark,
        input logic hw);
        logic sw;
        sw = cur;
        if (wr && mark) begin
            sw = wd[`CMDIRQ_BIT_SETSEL];
        end
        flag_next = sw | hw;
    endfunction

    logic wr_cmd;
    logic wr_comien;
    logic wr_auxien;
    logic wr_comirq;
    logic wr_auxirq;
    assign wr_cmd = reg_wr_i && (reg_addr_i == `CMDIRQ_ADDR_CMD);
    assign wr_comien = reg_wr_i && (reg_addr_i == `CMDIRQ_ADDR_COMIEN);
    assign wr_auxien = reg_wr_i && (reg_addr_i == `CMDIRQ_ADDR_AUXIEN);
    assign wr_comirq = reg_wr_i && (reg_addr_i == `CMDIRQ_ADDR_COMIRQ);
    assign wr_auxirq = reg_wr_i && (reg_addr_i == `CMDIRQ_ADDR_AUXIRQ);

    // ==========================================================================
    // Command register
    logic rcv_off_r;
    logic [3:0] cmd_r;
    logic cmd_start_r;
    logic bad_cmd_r;
    cmdirq_pwr_t pwr_r;
    logic [15:0] wake_cnt_r;

    always_ff @(posedge ref_clk_i) begin
        if (!resetn_i) begin
            rcv_off_r <= RECEIVER_ANALOG_DISABLE_RST;
        end else if (wr_cmd) begin
            rcv_off_r <= reg_wdata_i[`CMDIRQ_BIT_RECEIVER_ANALOG_DISABLE];
        end
    end

    // The no-change code is not a command, so it neither starts a command nor counts as unknown; its sleep bit still acts.
    logic cmd_write;
    logic cmd_accept;
    logic cmd_reject;
    assign cmd_write = wr_cmd && (reg_wdata_i[3:0] != CMDIRQ_NOCHANGE);
    assign cmd_accept = cmd_write && cmd_known(reg_wdata_i[3:0]);
    assign cmd_reject = cmd_write && !cmd_known(reg_wdata_i[3:0]);

    // A host write of any code but no-change wins over a completion in the same cycle.
    always_ff @(posedge ref_clk_i) begin
        if (!resetn_i) begin
            cmd_r <= CODE_RST;
        end else if (cmd_accept) begin
            cmd_r <= reg_wdata_i[3:0];
        end else if (cmd_reject) begin
            cmd_r <= CMDIRQ_IDLE;
        end else if (cmd_done_i) begin
            cmd_r <= CMDIRQ_IDLE;
        end
    end

    always_ff @(posedge ref_clk_i) begin
        if (!resetn_i) begin
            cmd_start_r <= 1'b0;
        end else begin
            cmd_start_r <= cmd_accept;
        end
    end

    // The idle flag is raised one cycle late, which keeps the flag logic off the write path.
    always_ff @(posedge ref_clk_i) begin
        if (!resetn_i) begin
            bad_cmd_r <= 1'b0;
        end else begin
            bad_cmd_r <= cmd_reject;
        end
    end

    logic sleep_set;
    logic wake_start;
    cmdirq_pwr_t pwr_nxt;
    assign sleep_set = wr_cmd && reg_wdata_i[`CMDIRQ_BIT_SLEEP] && (cmd_r != CMDIRQ_SOFTWARE_RESTART_CMD);
    assign wake_start = wr_cmd && !reg_wdata_i[`CMDIRQ_BIT_SLEEP];

    // Wake-up holds the bit at one so software polling sees ready only after the count.
    always_comb begin
        pwr_nxt = pwr_r;
        case (pwr_r)
            CMDIRQ_PWR_ON: begin
                if (sleep_set) begin
                    pwr_nxt = CMDIRQ_PWR_DOWN;
                end
            end
            CMDIRQ_PWR_DOWN: begin
                if (wake_start) begin
                    pwr_nxt = CMDIRQ_PWR_WAKE;
                end
            end
            CMDIRQ_PWR_WAKE: begin
                if (wake_cnt_r == 16'h0000) begin
                    pwr_nxt = CMDIRQ_PWR_ON;
                end
            end
            default: pwr_nxt = CMDIRQ_PWR_ON;
        endcase
    end

    always_ff @(posedge ref_clk_i) begin
        if (!resetn_i) begin
            pwr_r <= CMDIRQ_PWR_ON;
        end else begin
            pwr_r <= pwr_nxt;
        end
    end

    // The counter loads only on the way into wake-up, so a second clear while waking does not restart it.
    always_ff @(posedge ref_clk_i) begin
        if (!resetn_i) begin
            wake_cnt_r <= 16'h0000;
        end else if (pwr_r == CMDIRQ_PWR_DOWN && wake_start) begin
            wake_cnt_r <= 16'(WAKE_CYCLES - 1);
        end else if (pwr_r == CMDIRQ_PWR_WAKE && wake_cnt_r != 16'h0000) begin
            wake_cnt_r <= wake_cnt_r - 16'h0001;
        end
    end

    // ==========================================================================
    // Enable registers
    logic [7:0] comien_r;
    logic [7:0] auxien_r;

    always_ff @(posedge ref_clk_i) begin
        if (!resetn_i) begin
            comien_r <= `CMDIRQ_RST_COMIEN;
        end else if (wr_comien) begin
            comien_r <= reg_wdata_i;
        end
    end

    always_ff @(posedge ref_clk_i) begin
        if (!resetn_i) begin
            auxien_r <= `CMDIRQ_RST_AUXIEN;
        end else if (wr_auxien) begin
            auxien_r <= reg_wdata_i & `CMDIRQ_AUX_MASK;
        end
    end

    // ==========================================================================
    // Request flags
    logic mod_s1_r;
    logic mod_s2_r;
    logic mod_s3_r;
    logic mod_edge;
    logic [6:0] comirq_r;
    logic [1:0] auxirq_r;
    logic [6:0] com_set;
    logic [1:0] aux_evt;

    always_ff @(posedge ref_clk_i) begin
        if (!resetn_i) begin
            mod_s1_r <= 1'b0;
            mod_s2_r <= 1'b0;
            mod_s3_r <= 1'b0;
        end else begin
            mod_s1_r <= modulation_input_pin_i;
            mod_s2_r <= mod_s1_r;
            mod_s3_r <= mod_s2_r;
        end
    end

    always_comb begin
        com_set = comm_event_i;
        com_set[`CMDIRQ_BIT_IDLE] = comm_event_i[`CMDIRQ_BIT_IDLE] | bad_cmd_r;
    end

    // Only synchronised copies are compared, so a pin edge never reaches the flag metastable.
    assign mod_edge = mod_s2_r ^ mod_s3_r;

    // Each flag bit is its own register; hardware set wins over a software clear in the same cycle.
    for (genvar b = 0; b < 7; b++) begin : g_comm_flag
        always_ff @(posedge ref_clk_i) begin
            if (!resetn_i) begin
                comirq_r[b] <= COMIRQ_RST[b];
            end else begin
                comirq_r[b] <= flag_next(comirq_r[b], wr_comirq, reg_wdata_i, reg_wdata_i[b], com_set[b]);
            end
        end
    end

    // Bit 1 holds modulation-input activity, bit 0 holds checksum done.
    assign aux_evt = {mod_edge, checksum_done_i};

    for (genvar b = 0; b < 2; b++) begin : g_aux_flag
        localparam int MARK_POS = (b == 1) ? `CMDIRQ_BIT_MODIN : `CMDIRQ_BIT_CRC;
        always_ff @(posedge ref_clk_i) begin
            if (!resetn_i) begin
                auxirq_r[b] <= 1'b0;
            end else begin
                auxirq_r[b] <= flag_next(auxirq_r[b], wr_auxirq, reg_wdata_i, reg_wdata_i[MARK_POS], aux_evt[b]);
            end
        end
    end

    // ==========================================================================
    // IRQ pin
    logic com_hit;
    logic aux_hit;
    logic irq_comb;
    logic irq_level;
    assign com_hit = |(comirq_r & comien_r[6:0]);
    assign aux_hit = (auxirq_r[1] & auxien_r[`CMDIRQ_BIT_MODIN])
        | (auxirq_r[0] & auxien_r[`CMDIRQ_BIT_CRC]);
    assign irq_comb = com_hit | aux_hit;
    assign irq_level = comien_r[`CMDIRQ_BIT_INV] ? ~irq_comb : irq_comb;

    // Open-drain drives only the low level; push-pull drives always.
    // Level and enable are registered from the same inputs, so they never disagree for a cycle.
    always_ff @(posedge ref_clk_i) begin
        if (!resetn_i) begin
            irq_out_o <= 1'b0;
        end else begin
            irq_out_o <= irq_level;
        end
    end

    always_ff @(posedge ref_clk_i) begin
        if (!resetn_i) begin
            irq_oe_n_o <= 1'b1;
        end else begin
            irq_oe_n_o <= auxien_r[`CMDIRQ_BIT_PUSHPULL] ? 1'b0 : irq_level;
        end
    end

    // ==========================================================================
    // Read-back
    // Unmapped and reserved locations read zero, so software never sees stale bus data.
    logic [7:0] rd_mux;

    always_comb begin
        rd_mux = 8'h00;
        case (reg_addr_i)
            `CMDIRQ_ADDR_CMD: rd_mux = {2'b00, rcv_off_r, pwr_r != CMDIRQ_PWR_ON, cmd_r};
            `CMDIRQ_ADDR_COMIEN: rd_mux = comien_r;
            `CMDIRQ_ADDR_AUXIEN: rd_mux = auxien_r;
            `CMDIRQ_ADDR_COMIRQ: rd_mux = {1'b0, comirq_r};
            `CMDIRQ_ADDR_AUXIRQ: rd_mux = {3'b000, auxirq_r[1], 1'b0, auxirq_r[0], 2'b00};
            default: rd_mux = 8'h00;
        endcase
    end

    // The read data holds until the next read strobe.
    always_ff @(posedge ref_clk_i) begin
        if (!resetn_i) begin
            reg_rdata_o <= 8'h00;
        end else if (reg_rd_i) begin
            reg_rdata_o <= rd_mux;
        end
    end

    assign receiver_analog_disable_o = rcv_off_r;
    assign sleep_o = (pwr_r == CMDIRQ_PWR_DOWN);
    assign cmd_active_o = cmd_r;
    assign cmd_start_o = cmd_start_r;
endmodule

// File: shared/cmdirq_consts.svh
`ifndef CMDIRQ_CONSTS_SVH
`define CMDIRQ_CONSTS_SVH
// ==========================================================================
// Register offsets
`define CMDIRQ_ADDR_RSVD 6'h00
`define CMDIRQ_ADDR_CMD 6'h01
`define CMDIRQ_ADDR_COMIEN 6'h02
`define CMDIRQ_ADDR_AUXIEN 6'h03
`define CMDIRQ_ADDR_COMIRQ 6'h04
`define CMDIRQ_ADDR_AUXIRQ 6'h05
// ==========================================================================
// Reset values
`define CMDIRQ_RST_RSVD 8'h00
`define CMDIRQ_RST_CMD 8'h20
`define CMDIRQ_RST_COMIEN 8'h80
`define CMDIRQ_RST_AUXIEN 8'h00
`define CMDIRQ_RST_COMIRQ 7'h14
// ==========================================================================
// Field positions
`define CMDIRQ_BIT_RECEIVER_ANALOG_DISABLE 5
`define CMDIRQ_BIT_SLEEP 4
`define CMDIRQ_BIT_INV 7
`define CMDIRQ_BIT_PUSHPULL 7
`define CMDIRQ_BIT_MODIN 4
`define CMDIRQ_BIT_CRC 2
`define CMDIRQ_BIT_SETSEL 7
`define CMDIRQ_BIT_IDLE 4
`define CMDIRQ_AUX_MASK 8'h94
// ==========================================================================
// Timing
`define CMDIRQ_WAKE_NS 1000
`define CMDIRQ_CLK_NS 20
`define CMDIRQ_WAKE_CYC ((`CMDIRQ_WAKE_NS + `CMDIRQ_CLK_NS - 1) / `CMDIRQ_CLK_NS)
`endif

// File: shared/cmdirq_pkg.sv
package cmdirq_pkg;
    typedef enum logic [3:0] {
        CMDIRQ_IDLE = 4'h0,
        CMDIRQ_MEM = 4'h1,
        CMDIRQ_RANDID = 4'h2,
        CMDIRQ_CALCCRC = 4'h3,
        CMDIRQ_TRANSMIT = 4'h4,
        CMDIRQ_NOCHANGE = 4'h7,
        CMDIRQ_RECEIVE = 4'h8,
        CMDIRQ_TRANSCEIVE = 4'hC,
        CMDIRQ_AUTH = 4'hE,
        CMDIRQ_SOFTWARE_RESTART_CMD = 4'hF
    } cmdirq_cmd_t;
    typedef enum {
        CMDIRQ_PWR_ON,
        CMDIRQ_PWR_DOWN,
        CMDIRQ_PWR_WAKE
    } cmdirq_pwr_t;
endpackage

// File: test/cmdirq_host.sv
`timescale 1ns/1ps
// ========
// Host side of the register port.
module cmdirq_host (
    input wire logic ref_clk_i,
    input wire logic [7:0] rdata_i,
    output logic [5:0] addr_o,
    output logic wr_o,
    output logic rd_o,
    output logic [7:0] wdata_o
);
    initial begin
        addr_o = 6'h2A;
        wr_o = 1'b0;
        rd_o = 1'b0;
        wdata_o = 8'h5A;
    end
    // An idle bus shows the inverse of the last value, so a stale match never passes.
    task automatic wr(input logic [5:0] a, input logic [7:0] d);
        @(negedge ref_clk_i);
        addr_o = a;
        wdata_o = d;
        wr_o = 1'b1;
        @(negedge ref_clk_i);
        wr_o = 1'b0;
        addr_o = ~a;
        wdata_o = ~d;
    endtask
    task automatic rd(input logic [5:0] a, output logic [7:0] d);
        @(negedge ref_clk_i);
        addr_o = a;
        rd_o = 1'b1;
        @(negedge ref_clk_i);
        rd_o = 1'b0;
        addr_o = ~a;
        @(negedge ref_clk_i);
        d = rdata_i;
    endtask
endmodule

// File: test/cmdirq_regs_assertions.sv
`timescale 1ns/1ps
// ========
// Port checks.
module cmdirq_chk (
    input wire logic ref_clk_i,
    input wire logic resetn_i,
    input wire logic [5:0] reg_addr_i,
    input wire logic reg_wr_i,
    input wire logic reg_rd_i,
    input wire logic [7:0] reg_wdata_i,
    input wire logic [7:0] reg_rdata_o,
    input wire logic cmd_done_i,
    input wire logic receiver_analog_disable_o,
    input wire logic sleep_o,
    input wire logic [3:0] cmd_active_o,
    input wire logic cmd_start_o,
    input wire logic irq_out_o,
    input wire logic irq_oe_n_o
);
    default clocking @(posedge ref_clk_i); endclocking
    default disable iff (!resetn_i);
    sequence s_cw;
        reg_wr_i && reg_addr_i == 6'h01 && !cmd_done_i;
    endsequence
    a_rcv_off_track: assert property (s_cw |=> receiver_analog_disable_o == $past(reg_wdata_i[5]))
        else $error("rcv off");
    a_cmd_start_run: assert property (s_cw ##0 reg_wdata_i[3:0] == 4'hC |=> cmd_active_o == 4'hC && cmd_start_o)
        else $error("cmd start");
    a_start_one_cycle: assert property (cmd_start_o |=> !cmd_start_o)
        else $error("start pulse");
    a_unknown_to_idle: assert property (s_cw ##0 reg_wdata_i[3:0] == 4'h5 |=> cmd_active_o == 4'h0)
        else $error("unknown code");
    a_sleep_enter: assert property (s_cw ##0 (reg_wdata_i[4] && reg_wdata_i[3:0] != 4'hF && cmd_active_o != 4'hF)
        |=> sleep_o)
        else $error("sleep");
    a_sleep_refused: assert property (s_cw ##0 (cmd_active_o == 4'hF && !sleep_o) |=> !sleep_o)
        else $error("sleep refuse");
    a_rsvd_reads_zero: assert property (reg_rd_i && reg_addr_i == 6'h00 |=> reg_rdata_o == 8'h00)
        else $error("reserved");
    a_cmd_top_zero: assert property (reg_rd_i && reg_addr_i == 6'h01 |=> reg_rdata_o[7:6] == 2'h0)
        else $error("cmd top");
    a_aux_rsvd_zero: assert property (reg_rd_i && reg_addr_i == 6'h03 |=> (reg_rdata_o & 8'h6B) == 8'h00)
        else $error("aux rsvd");
    a_od_drive_low: assert property (resetn_i && $past(resetn_i) && irq_oe_n_o |-> irq_out_o)
        else $error("open drain");
endmodule
bind cmdirq_regs cmdirq_chk chk_u (.ref_clk_i, .resetn_i, .reg_addr_i, .reg_wr_i, .reg_rd_i, .reg_wdata_i,
    .reg_rdata_o, .cmd_done_i, .receiver_analog_disable_o, .sleep_o, .cmd_active_o, .cmd_start_o, .irq_out_o,
    .irq_oe_n_o);

// File: test/tb_top.sv
`timescale 1ns/1ps
// ========
// Bench.
module tb_top;
    logic ref_clk_i, resetn_i, cmd_done_i, checksum_done_i, modulation_input_pin_i, reg_wr_i, reg_rd_i;
    logic receiver_analog_disable_o, sleep_o, cmd_start_o, irq_out_o, irq_oe_n_o;
    logic [5:0] reg_addr_i;
    logic [7:0] reg_wdata_i, reg_rdata_o, d;
    logic [6:0] comm_event_i;
    logic [3:0] cmd_active_o;
    logic [7:0] codes [7] = '{8'h01, 8'h02, 8'h03, 8'h04, 8'h08, 8'h0C, 8'h0E};
    int n_errors = 0, total_checks = 0, cf = 0, af = 0, ce = 0, ae = 0;
    cmdirq_regs #(.WAKE_CYCLES(3)) dut_u (.ref_clk_i, .resetn_i, .reg_addr_i, .reg_wr_i, .reg_rd_i, .reg_wdata_i,
        .reg_rdata_o, .comm_event_i, .checksum_done_i, .cmd_done_i, .modulation_input_pin_i, .receiver_analog_disable_o,
        .sleep_o, .cmd_active_o, .cmd_start_o, .irq_out_o, .irq_oe_n_o);
    cmdirq_host host_u (.ref_clk_i, .rdata_i(reg_rdata_o), .addr_o(reg_addr_i), .wr_o(reg_wr_i), .rd_o(reg_rd_i),
        .wdata_o(reg_wdata_i));
    initial begin
        ref_clk_i = 1'b0;
        forever #10 ref_clk_i = ~ref_clk_i;
    end
    task automatic chk8(input logic [7:0] g, input logic [7:0] e);
        total_checks++;
        if (g !== e) begin
            n_errors++;
            $display("wrong value at %0t: read %h, model %h", $time, g, e);
        end
    endtask
    task automatic chk1(input logic g, input logic e);
        total_checks++;
        if (g !== e) begin
            n_errors++;
            $display("wrong value at %0t: pin %b, model %b", $time, g, e);
        end
    endtask
    task automatic rchk(input logic [5:0] a, input logic [7:0] e);
        host_u.rd(a, d);
        chk8(d, e);
    endtask
    // The pin model: any enabled flag raises the combined bit, bit 7 of the enable register inverts it.
    task automatic irq_chk;
        repeat (6) @(negedge ref_clk_i);
        chk1(irq_out_o, logic'(((cf & ce & 127) | (af & ae & 20)) != 0) ^ ce[7]);
    endtask
    task automatic pulse_done;
        @(negedge ref_clk_i);
        cmd_done_i = 1'b1;
        @(negedge ref_clk_i);
        cmd_done_i = 1'b0;
    endtask
    task automatic test_done;
        if (n_errors == 0 && total_checks > 0) $display("[ PASS ]");
        else $display("[ FAIL ]");
        $finish;
    endtask
    initial begin
        resetn_i = 1'b0;
        cmd_done_i = 1'b0;
        checksum_done_i = 1'b0;
        modulation_input_pin_i = 1'b0;
        comm_event_i = 7'h00;
        void'($urandom(77));
        repeat (5) @(negedge ref_clk_i);
        resetn_i = 1'b1;
        rchk(6'h00, 8'h00);
        rchk(6'h01, 8'h20);
        rchk(6'h02, 8'h80);
        rchk(6'h03, 8'h00);
        host_u.wr(6'h00, 8'hFF);
        rchk(6'h00, 8'h00);
        rchk(6'h3F, 8'h00);
        foreach (codes[i]) begin
            d = 8'($urandom) & 8'h20 | codes[i];
            host_u.wr(6'h01, d);
            rchk(6'h01, d);
            pulse_done;
        end
        host_u.wr(6'h01, 8'h03);
        host_u.wr(6'h01, 8'h07);
        rchk(6'h01, 8'h03);
        host_u.wr(6'h01, 8'h05);
        rchk(6'h01, 8'h00);
        host_u.wr(6'h01, 8'h10);
        @(negedge ref_clk_i);
        chk1(sleep_o, 1'b1);
        host_u.wr(6'h01, 8'h00);
        d = 8'h10;
        for (int k = 0; k < 30 && d[4] !== 1'b0; k++) host_u.rd(6'h01, d);
        chk8(d, 8'h00);
        if (d[4] !== 1'b0) test_done;
        host_u.wr(6'h01, 8'h0F);
        host_u.wr(6'h01, 8'h1F);
        @(negedge ref_clk_i);
        chk1(sleep_o, 1'b0);
        pulse_done;
        host_u.wr(6'h04, 8'h7F);
        host_u.wr(6'h05, 8'h14);
        rchk(6'h04, 8'h00);
        host_u.wr(6'h04, 8'h88);
        rchk(6'h04, 8'h08);
        host_u.wr(6'h04, 8'h08);
        for (int i = 0; i < 7; i++) begin
            ce = ($urandom & 255) | (1 << i);
            host_u.wr(6'h02, 8'(ce));
            rchk(6'h02, 8'(ce));
            irq_chk;
            @(negedge ref_clk_i);
            comm_event_i = 7'(1 << i);
            @(negedge ref_clk_i);
            comm_event_i = 7'h00;
            cf = 1 << i;
            irq_chk;
            host_u.wr(6'h04, 8'(cf));
            cf = 0;
            irq_chk;
        end
        ce = 0;
        ae = 'h94;
        host_u.wr(6'h02, 8'h00);
        host_u.wr(6'h03, 8'hFF);
        rchk(6'h03, 8'h94);
        chk1(irq_oe_n_o, 1'b0);
        modulation_input_pin_i = 1'b1;
        af = 'h10;
        irq_chk;
        host_u.wr(6'h05, 8'h10);
        af = 0;
        @(negedge ref_clk_i);
        checksum_done_i = 1'b1;
        @(negedge ref_clk_i);
        checksum_done_i = 1'b0;
        af = 4;
        irq_chk;
        host_u.wr(6'h03, 8'h14);
        ae = 'h14;
        irq_chk;
        chk1(irq_oe_n_o, 1'b1);
        test_done;
    end
endmodule
